// ---- ias_pkg.sv ----
// Behaviour
// - bus reset clears control, data, status and vector state.
// - four-bit input select picks channel 1-16, or 1-8 when paired.
// - paired select forms 8 pairs, inputs 9-16 as second legs.
// - amplifier factor codes map to gains 1,2,5,10 or 1,2,4,8 by family.
// - settling flag is 1 for about 10 us after each control write.
// - with auto settle off, trigger write starts a conversion at once.
// - trigger writes while conversion busy is 1 are ignored.
// - control write with auto settle starts conversion when settling ends.
// - in auto mode busy covers settling and conversion.
// - result lag off loads current result; on loads previous one.
// - 12-bit result is left aligned, low four bits zero.
// - bipolar gives two's complement, unipolar straight binary.
// - with irq allow, settle done raises request 1, data ready request 0.
// - settle done interrupt on settling flag fall, host-triggered mode only.
// - data ready interrupt on busy flag fall.
// - acknowledge returns vector bits 7:1, bit 0 one for settle done.
// - acknowledge cycle clears the pending interrupt it serves.
// - vector read in I/O space returns bit 0 as zero.
// - control bits 15:10 ignore writes; status bits 7:2 undefined.
// - ID accesses take one wait state, I/O and acknowledge none.
// - control write during a conversion settles alongside it.
package ias_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 125;
	localparam int SETTLE_TIME_NS   = 10000;
	localparam int SETTLE_CYCLES    = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int ID_WAIT_STATES   = 1;
	localparam int IO_WAIT_STATES   = 0;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [6:0] OFS_CTRL   = 7'h00;
	localparam logic [6:0] OFS_RESULT = 7'h02;
	localparam logic [6:0] OFS_FLAGS  = 7'h05;
	localparam logic [6:0] OFS_TRIG   = 7'h07;
	localparam logic [6:0] OFS_VECTOR = 7'h09;
	localparam logic [6:0] OFS_UNLOCK = 7'h0b;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int FLAG_SETTLE_BIT = 0;
	localparam int FLAG_BUSY_BIT   = 1;
	localparam int VEC_SETTLE_ID   = 1;

	typedef struct packed {
		logic       irq_allow;
		logic       result_lag_enable;
		logic       auto_settle_enable;
		logic [1:0] amp_factor;
		logic       paired_input_select;
		logic [3:0] input_select;
	} ias_ctrl_t;

	typedef struct packed {
		logic [3:0] pos;
		logic [3:0] neg;
		logic       paired;
		logic [3:0] gain;
	} ias_mux_t;

	typedef enum logic [2:0] {
		CONV_IDLE   = 3'b001,
		CONV_LAUNCH = 3'b010,
		CONV_RUN    = 3'b100
	} ias_conv_t;

	typedef struct packed {
		ias_ctrl_t   ctrl;
		ias_mux_t    mux;
		logic [15:0] result;
		logic [15:0] last;
		logic [6:0]  vec;
		logic        irq_settle;
		logic        irq_data;
		logic        auto_wait;
		ias_conv_t   conv;
		logic        start;
		logic        settle_d;
		logic        busy_d;
		logic        acc_open;
		logic        id_wait;
		logic        ack;
		logic [15:0] rdata;
	} ias_seq_state_t;

	localparam ias_ctrl_t   CTRL_RST   = 10'h000;
	localparam ias_mux_t    MUX_RST    = 13'h0001;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [6:0]  VEC_RST    = 7'h00;
	localparam logic [15:0] ID_RDATA   = 16'h0000;

	localparam logic [3:0] GAIN_FAM_A [4] = '{4'h1, 4'h2, 4'h5, 4'ha};
	localparam logic [3:0] GAIN_FAM_B [4] = '{4'h1, 4'h2, 4'h4, 4'h8};

	localparam ias_seq_state_t SEQ_RST = '{
		ctrl:       CTRL_RST,
		mux:        MUX_RST,
		result:     RESULT_RST,
		last:       RESULT_RST,
		vec:        VEC_RST,
		irq_settle: 1'b0,
		irq_data:   1'b0,
		auto_wait:  1'b0,
		conv:       CONV_IDLE,
		start:      1'b0,
		settle_d:   1'b0,
		busy_d:     1'b0,
		acc_open:   1'b0,
		id_wait:    1'b0,
		ack:        1'b0,
		rdata:      16'h0000
	};

endpackage

// ---- ias_sync.sv ----
`timescale 1ns/1ns
module ias_sync #(
	parameter int W = 1
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} ias_sync_state_t;

	ias_sync_state_t st_r;
	ias_sync_state_t st_nxt;

	// s1 feeds only s2; value moves once s2 and s3 agree
	always_comb
	begin
		st_nxt    = st_r;
		st_nxt.s1 = i_async;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3)
		begin
			st_nxt.q = st_r.s3;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_sync = st_r.q;
endmodule // ias_sync

// ---- ias_settle_timer.sv ----
`timescale 1ns/1ns
module ias_settle_timer #(
	parameter int CYCLES = ias_pkg::SETTLE_CYCLES,
	parameter int CW     = $clog2(CYCLES + 1)
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_reload,
	output logic      o_busy,
	output logic      o_expire
);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          busy;
		logic          expire;
	} ias_tmr_state_t;

	ias_tmr_state_t st_r;
	ias_tmr_state_t st_nxt;

	always_comb
	begin
		st_nxt        = st_r;
		st_nxt.expire = 1'b0;
		if (i_reload)
		begin
			// restart on every control write, even mid-count
			st_nxt.cnt  = LOAD;
			st_nxt.busy = 1'b1;
		end
		else if (st_r.busy)
		begin
			st_nxt.cnt = st_r.cnt - 1'b1;
			if (st_r.cnt == CW'(1))
			begin
				st_nxt.busy   = 1'b0;
				st_nxt.expire = 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_busy   = st_r.busy;
	assign o_expire = st_r.expire;
endmodule // ias_settle_timer

// ---- ias_sequencer.sv ----
`timescale 1ns/1ns
module ias_sequencer #(
	parameter bit BIPOLAR     = 1'b1,
	parameter bit GAIN_FAMILY = 1'b0,
	parameter int SETTLE_CYC  = ias_pkg::SETTLE_CYCLES
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_io_sel_n,
	input  wire logic        i_id_sel_n,
	input  wire logic        i_int_sel_n,
	input  wire logic        i_wr_n,
	input  wire logic [1:0]  i_be_n,
	input  wire logic [5:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	output logic      [15:0] o_rdata,
	output logic             o_ack_n,
	output logic      [1:0]  o_irq_n,
	output logic      [3:0]  o_mux_pos,
	output logic      [3:0]  o_mux_neg,
	output logic             o_mux_paired,
	output logic      [3:0]  o_gain_factor,
	output logic             o_conv_start,
	input  wire logic        i_adc_busy,
	input  wire logic [11:0] i_adc_data
);
	// ----------------------------------------------------------------
	// state and helpers
	// ----------------------------------------------------------------
	ias_pkg::ias_seq_state_t st_r;
	ias_pkg::ias_seq_state_t st_nxt;

	logic        adc_busy;
	logic [11:0] adc_data;
	logic        tmr_busy;
	logic        tmr_expire;
	logic        ctrl_wr;

	ias_sync #(
		.W (1)
	) u_sync_busy (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_async    (i_adc_busy),
		.o_sync     (adc_busy)
	);

	// data is held steady by the converter while busy is low
	ias_sync #(
		.W (12)
	) u_sync_data (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_async    (i_adc_data),
		.o_sync     (adc_data)
	);

	ias_settle_timer #(
		.CYCLES (SETTLE_CYC)
	) u_settle (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_reload   (ctrl_wr),
		.o_busy     (tmr_busy),
		.o_expire   (tmr_expire)
	);

	function automatic logic [15:0] fmt_result(input logic [11:0] raw);
		logic [11:0] code;
		code = raw;
		if (BIPOLAR)
		begin
			code[11] = ~raw[11];
		end
		return {code, 4'h0};
	endfunction

	function automatic ias_pkg::ias_mux_t mux_of(input ias_pkg::ias_ctrl_t c);
		ias_pkg::ias_mux_t m;
		m = ias_pkg::MUX_RST;
		m.paired = c.paired_input_select;
		if (c.paired_input_select)
		begin
			// codes above 0111 fold onto pairs 1-8
			m.pos = {1'b0, c.input_select[2:0]};
			m.neg = {1'b1, c.input_select[2:0]};
		end
		else
		begin
			m.pos = c.input_select;
			m.neg = 4'h0;
		end
		if (GAIN_FAMILY)
			m.gain = ias_pkg::GAIN_FAM_B[c.amp_factor];
		else
			m.gain = ias_pkg::GAIN_FAM_A[c.amp_factor];
		return m;
	endfunction

	// ----------------------------------------------------------------
	// bus decode and sequencing
	// ----------------------------------------------------------------
	logic        sel_any;
	logic        take;
	logic        io_take;
	logic        int_take;
	logic        wr;
	logic        rd;
	logic        trig_wr;
	logic        conv_busy;
	logic        start_now;
	logic        adc_done;
	logic        settle_fall;
	logic        busy_fall;
	logic [15:0] fresh;
	ias_pkg::ias_ctrl_t wctrl;

	always_comb
	begin
		st_nxt       = st_r;
		st_nxt.start = 1'b0;
		st_nxt.ack   = 1'b0;
		wctrl        = st_r.ctrl;
		fresh        = fmt_result(adc_data);

		sel_any  = ~i_io_sel_n | ~i_id_sel_n | ~i_int_sel_n;
		take     = sel_any & ~st_r.acc_open;
		io_take  = take & ~i_io_sel_n;
		int_take = take & ~i_int_sel_n;
		wr       = io_take & ~i_wr_n;
		rd       = io_take & i_wr_n;
		ctrl_wr  = wr & (i_addr == ias_pkg::OFS_CTRL[6:1]);
		trig_wr  = wr & (i_addr == ias_pkg::OFS_TRIG[6:1]);

		conv_busy = st_r.auto_wait | (st_r.conv != ias_pkg::CONV_IDLE);

		// one access per select; host drops select after ack
		if (!sel_any)
			st_nxt.acc_open = 1'b0;
		else if (take)
			st_nxt.acc_open = 1'b1;

		if (io_take | int_take)
		begin
			st_nxt.ack = 1'b1;
		end
		if (take & ~i_id_sel_n)
		begin
			st_nxt.id_wait = 1'b1;
		end
		if (st_r.id_wait)
		begin
			st_nxt.id_wait = 1'b0;
			st_nxt.ack     = 1'b1;
			st_nxt.rdata   = ias_pkg::ID_RDATA;
		end

		// register writes
		if (ctrl_wr)
		begin
			if (!i_be_n[0])
			begin
				wctrl[7:0] = i_wdata[7:0];
			end
			if (!i_be_n[1])
			begin
				wctrl[9:8] = i_wdata[9:8];
			end
			st_nxt.ctrl      = wctrl;
			st_nxt.mux       = mux_of(wctrl);
			st_nxt.auto_wait = wctrl.auto_settle_enable;
		end
		if (wr && i_addr == ias_pkg::OFS_RESULT[6:1])
		begin
			if (!i_be_n[0])
			begin
				st_nxt.result[7:0] = i_wdata[7:0];
			end
			if (!i_be_n[1])
			begin
				st_nxt.result[15:8] = i_wdata[15:8];
			end
		end
		if (wr && !i_be_n[0] && i_addr == ias_pkg::OFS_VECTOR[6:1])
		begin
			st_nxt.vec = i_wdata[7:1];
		end

		// register reads
		if (rd)
		begin
			st_nxt.rdata = 16'h0000;
			if (i_addr == ias_pkg::OFS_CTRL[6:1])
			begin
				st_nxt.rdata[9:0] = st_r.ctrl;
			end
			else if (i_addr == ias_pkg::OFS_RESULT[6:1])
			begin
				st_nxt.rdata = st_r.result;
			end
			else if (i_addr == ias_pkg::OFS_FLAGS[6:1])
			begin
				st_nxt.rdata[ias_pkg::FLAG_SETTLE_BIT] = tmr_busy;
				st_nxt.rdata[ias_pkg::FLAG_BUSY_BIT]   = conv_busy;
			end
			else if (i_addr == ias_pkg::OFS_VECTOR[6:1])
			begin
				st_nxt.rdata[7:0] = {st_r.vec, 1'b0};
			end
		end

		// interrupt acknowledge: A1 high serves request 1
		if (int_take)
		begin
			if (i_addr[0])
			begin
				st_nxt.rdata      = {8'h00, st_r.vec, 1'b1};
				st_nxt.irq_settle = 1'b0;
			end
			else
			begin
				st_nxt.rdata    = {8'h00, st_r.vec, 1'b0};
				st_nxt.irq_data = 1'b0;
			end
		end

		// conversion launch
		start_now = (trig_wr & ~st_r.ctrl.auto_settle_enable & ~conv_busy)
			| (st_r.auto_wait & ~tmr_busy
			& (st_r.conv == ias_pkg::CONV_IDLE));
		adc_done  = 1'b0;

		unique case (st_r.conv)
			ias_pkg::CONV_IDLE:
			begin
				if (start_now)
				begin
					st_nxt.conv      = ias_pkg::CONV_LAUNCH;
					st_nxt.start     = 1'b1;
					st_nxt.auto_wait = 1'b0;
					if (st_r.ctrl.result_lag_enable)
					begin
						st_nxt.result = st_r.last;
					end
				end
			end
			ias_pkg::CONV_LAUNCH:
			begin
				if (adc_busy)
				begin
					st_nxt.conv = ias_pkg::CONV_RUN;
				end
			end
			ias_pkg::CONV_RUN:
			begin
				if (!adc_busy)
				begin
					adc_done    = 1'b1;
					st_nxt.conv = ias_pkg::CONV_IDLE;
				end
			end
		endcase

		if (adc_done)
		begin
			st_nxt.last = fresh;
			if (!st_r.ctrl.result_lag_enable)
			begin
				st_nxt.result = fresh;
			end
		end

		// edge detection; a set in the clear cycle wins
		st_nxt.settle_d = tmr_busy;
		st_nxt.busy_d   = conv_busy;
		settle_fall     = st_r.settle_d & ~tmr_busy;
		busy_fall       = st_r.busy_d & ~conv_busy;
		if (settle_fall && st_r.ctrl.irq_allow
			&& !st_r.ctrl.auto_settle_enable)
		begin
			st_nxt.irq_settle = 1'b1;
		end
		if (busy_fall && st_r.ctrl.irq_allow)
		begin
			st_nxt.irq_data = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			st_r <= ias_pkg::SEQ_RST;
		else
			st_r <= st_nxt;
	end

	assign o_rdata       = st_r.rdata;
	assign o_ack_n       = ~st_r.ack;
	assign o_irq_n       = ~{st_r.irq_settle, st_r.irq_data};
	assign o_mux_pos     = st_r.mux.pos;
	assign o_mux_neg     = st_r.mux.neg;
	assign o_mux_paired  = st_r.mux.paired;
	assign o_gain_factor = st_r.mux.gain;
	assign o_conv_start  = st_r.start;
endmodule // ias_sequencer

// ---- ias_sequencer_monitor.sv ----
`timescale 1ns/1ns
module ias_sequencer_monitor (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_io_sel_n,
	input  wire logic        i_id_sel_n,
	input  wire logic        i_int_sel_n,
	input  wire logic        i_wr_n,
	input  wire logic [1:0]  i_be_n,
	input  wire logic [5:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic [15:0] o_rdata,
	input  wire logic        o_ack_n,
	input  wire logic [1:0]  o_irq_n,
	input  wire logic [3:0]  o_mux_pos,
	input  wire logic [3:0]  o_mux_neg,
	input  wire logic        o_mux_paired,
	input  wire logic        o_conv_start
);
	// ----
	// helpers
	// ----
	// a take needs all selects high on the edge before
	logic        idle_q;
	logic [15:0] wd_q;
	logic        io_q;
	always_ff @(posedge i_core_clk)
	begin
		idle_q <= i_io_sel_n & i_id_sel_n & i_int_sel_n;
		wd_q   <= i_wdata;
	end
	assign io_q = idle_q & ~i_io_sel_n & i_id_sel_n & i_int_sel_n;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	AST_RST_OUT: assert property ($fell(i_rst) |-> o_ack_n
		&& o_irq_n == 2'b11 && !o_conv_start && o_rdata == 16'h0000)
		else $error("outputs not cleared by reset");
	AST_ACK_ONE: assert property (!o_ack_n |=> o_ack_n)
		else $error("ack longer than one cycle");
	AST_IO_ACK: assert property (io_q |=> !o_ack_n)
		else $error("io access not acked next cycle");
	AST_ID_ACK: assert property (
		idle_q && !i_id_sel_n && i_io_sel_n && i_int_sel_n
		|=> o_ack_n ##1 !o_ack_n)
		else $error("id access wait state wrong");
	AST_START_ONE: assert property (o_conv_start |=> !o_conv_start)
		else $error("start pulse too long");
	AST_IRQ_HOLD: assert property (
		!o_irq_n[0] && i_int_sel_n |=> !o_irq_n[0])
		else $error("request dropped without ack");
	AST_ACK_CLR: assert property (
		idle_q && !i_int_sel_n && i_io_sel_n && i_id_sel_n && i_addr[0]
		|=> o_irq_n[1])
		else $error("ack did not clear request");
	AST_CTRL_WR: assert property (
		io_q && !i_wr_n && i_addr == 6'h00 && i_be_n == 2'b00
		|=> o_mux_paired == wd_q[4]
		&& o_mux_pos == (wd_q[4] ? {1'b0, wd_q[2:0]} : wd_q[3:0]))
		else $error("mux select not taken from write");
	AST_MUX_NEG: assert property (
		o_mux_neg == (o_mux_paired ? {1'b1, o_mux_pos[2:0]} : 4'h0))
		else $error("second leg wrong");
	AST_VEC_BIT0: assert property (
		io_q && i_wr_n && i_addr == 6'h04 |=> !o_rdata[0])
		else $error("vector bit 0 set in io read");
endmodule // ias_sequencer_monitor

// ---- ias_adc_model.sv ----
`timescale 1ns/1ns
module ias_adc_model #(
	parameter int CONV_CYC = 20
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_start,
	input  wire logic [11:0] i_sample,
	output logic             o_busy,
	output logic      [11:0] o_data
);
	int cnt = 0;
	// outputs settle on the second edge, once start is out of reset, well inside the reset time
	// data toggles until three cycles before busy falls so a stale sample cannot pass
	always @(posedge i_core_clk)
	begin
		if (i_start)
			cnt <= CONV_CYC;
		else if (cnt > 0)
			cnt <= cnt - 1;
		o_busy <= i_start || cnt > 1;
		o_data <= (i_start || cnt > 4) ? ~o_data : i_sample;
	end
endmodule // ias_adc_model

// ---- ias_sequencer_tb.sv ----
`timescale 1ns/1ns
module ias_sequencer_tb;
	logic        i_core_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_io_sel_n = 1'b1;
	logic        i_id_sel_n = 1'b1;
	logic        i_int_sel_n = 1'b1;
	logic        i_wr_n = 1'b1;
	logic [1:0]  i_be_n = 2'b00;
	logic [5:0]  i_addr = 6'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic [11:0] sample = 12'h000;
	logic [15:0] rd;
	logic [15:0] o_rdata;
	logic        o_ack_n;
	logic [1:0]  o_irq_n;
	logic [3:0]  o_mux_pos;
	logic [3:0]  o_mux_neg;
	logic        o_mux_paired;
	logic [3:0]  o_gain_factor;
	logic        o_conv_start;
	logic        i_adc_busy;
	logic [11:0] i_adc_data;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          starts = 0;
	int          cycles = 0;
	logic [3:0]  gains [4] = '{4'h1, 4'h2, 4'h5, 4'ha};
	logic [6:0]  rst_ofs [4] = '{7'h00, 7'h02, 7'h05, 7'h09};

	// small settle count keeps polling short
	ias_sequencer #(.SETTLE_CYC(40)) dut (
		.i_core_clk(i_core_clk), .i_rst(i_rst), .i_io_sel_n(i_io_sel_n),
		.i_id_sel_n(i_id_sel_n), .i_int_sel_n(i_int_sel_n),
		.i_wr_n(i_wr_n), .i_be_n(i_be_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .o_rdata(o_rdata), .o_ack_n(o_ack_n),
		.o_irq_n(o_irq_n), .o_mux_pos(o_mux_pos), .o_mux_neg(o_mux_neg),
		.o_mux_paired(o_mux_paired), .o_gain_factor(o_gain_factor),
		.o_conv_start(o_conv_start), .i_adc_busy(i_adc_busy),
		.i_adc_data(i_adc_data));
	ias_adc_model u_adc (.i_core_clk(i_core_clk), .i_start(o_conv_start),
		.i_sample(sample), .o_busy(i_adc_busy), .o_data(i_adc_data));

	always #4 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk)
	begin
		cycles <= cycles + 1;
		if (o_conv_start)
			starts <= starts + 1;
		if (cycles == 30000)
		begin
			n_mismatch = n_mismatch + 1;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// k: 0 io, 1 id, 2 int ack; request held through the ack edge
	task automatic bus(input int k, input logic w, input logic [6:0] ofs,
		input logic [15:0] d);
		int n;
		n = 0;
		@(negedge i_core_clk);
		i_io_sel_n = k != 0;
		i_id_sel_n = k != 1;
		i_int_sel_n = k != 2;
		i_wr_n = !w;
		i_addr = ofs[6:1];
		i_wdata = d;
		do
		begin
			@(posedge i_core_clk);
			#1;
			n++;
		end
		while (o_ack_n !== 1'b0 && n < 8);
		rd = o_rdata;
		chk(16'(n), k == 1 ? 16'h0002 : 16'h0001);
		@(posedge i_core_clk);
		@(negedge i_core_clk);
		{i_io_sel_n, i_id_sel_n, i_int_sel_n} = 3'b111;
	endtask
	task automatic rdchk(input logic [6:0] ofs, input logic [15:0] e);
		bus(0, 1'b0, ofs, 16'h0000);
		chk(rd, e);
	endtask
	// result and trigger are legal only once both flags are low
	task automatic wait_idle();
		int n;
		n = 0;
		do
		begin
			bus(0, 1'b0, 7'h05, 16'h0000);
			n++;
		end
		while (rd !== 16'h0000 && n < 200);
	endtask
	task automatic conv(input logic [11:0] s, input logic [15:0] e);
		sample = s;
		wait_idle();
		bus(0, 1'b1, 7'h07, 16'h00a5);
		rdchk(7'h05, 16'h0002);
		bus(0, 1'b1, 7'h07, 16'h005a);
		wait_idle();
		rdchk(7'h02, e);
	endtask

	// ----
	// sequence
	// ----
	initial
	begin
		repeat (6) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_rst = 1'b0;
		foreach (rst_ofs[i])
			rdchk(rst_ofs[i], 16'h0000);
		bus(1, 1'b0, 7'h01, 16'h0000);
		chk(rd, 16'h0000);
		for (int g = 0; g < 4; g++)
		begin
			bus(0, 1'b1, 7'h00, {9'h000, 2'(g), 5'h00});
			chk({12'h000, o_gain_factor}, {12'h000, gains[g]});
		end
		bus(0, 1'b1, 7'h00, 16'hfe3d);
		rdchk(7'h05, 16'h0001);
		chk({4'h0, o_mux_pos, o_mux_neg, 3'h0, o_mux_paired}, 16'h05d1);
		chk({12'h000, o_gain_factor}, 16'h0002);
		rdchk(7'h00, 16'h023d);
		bus(0, 1'b1, 7'h09, 16'h0061);
		rdchk(7'h09, 16'h0060);
		wait_idle();
		chk({14'h0000, o_irq_n}, 16'h0001);
		bus(2, 1'b0, 7'h02, 16'h0000);
		chk(rd, 16'h0061);
		chk({14'h0000, o_irq_n}, 16'h0003);
		conv(12'h123, 16'h9230);
		chk({14'h0000, o_irq_n}, 16'h0002);
		bus(2, 1'b0, 7'h00, 16'h0000);
		chk(rd, 16'h0060);
		conv(12'hfff, 16'h7ff0);
		conv(12'h800, 16'h0000);
		conv(12'h000, 16'h8000);
		bus(0, 1'b1, 7'h00, 16'h0100);
		conv(12'h456, 16'h8000);
		conv(12'h789, 16'hc560);
		bus(2, 1'b0, 7'h00, 16'h0000);
		// new selection settles while the running conversion goes on
		bus(0, 1'b1, 7'h07, 16'h0000);
		bus(0, 1'b1, 7'h00, 16'h0003);
		rdchk(7'h05, 16'h0003);
		wait_idle();
		rdchk(7'h02, 16'hf890);
		chk({12'h000, o_mux_pos}, 16'h0003);
		chk({14'h0000, o_irq_n}, 16'h0003);
		sample = 12'h0f0;
		bus(0, 1'b1, 7'h00, 16'h0280);
		rdchk(7'h05, 16'h0003);
		bus(0, 1'b1, 7'h07, 16'h0000);
		wait_idle();
		rdchk(7'h02, 16'h8f00);
		chk({14'h0000, o_irq_n}, 16'h0002);
		chk(16'(starts), 16'h0008);
		// reset while idle with control, result, vector and request set
		@(negedge i_core_clk);
		i_rst = 1'b1;
		repeat (2) @(negedge i_core_clk);
		i_rst = 1'b0;
		foreach (rst_ofs[i])
			rdchk(rst_ofs[i], 16'h0000);
		chk({14'h0000, o_irq_n}, 16'h0003);
		chk({12'h000, o_gain_factor}, 16'h0001);
		print_verdict();
	end
endmodule // ias_sequencer_tb

bind ias_sequencer ias_sequencer_monitor u_mon (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_io_sel_n(i_io_sel_n),
	.i_id_sel_n(i_id_sel_n), .i_int_sel_n(i_int_sel_n), .i_wr_n(i_wr_n),
	.i_be_n(i_be_n), .i_addr(i_addr), .i_wdata(i_wdata),
	.o_rdata(o_rdata), .o_ack_n(o_ack_n), .o_irq_n(o_irq_n),
	.o_mux_pos(o_mux_pos), .o_mux_neg(o_mux_neg),
	.o_mux_paired(o_mux_paired), .o_conv_start(o_conv_start));
